// ===== rtl/dma_cfg_pkg.sv
// Constants, types and layout for the two-channel DMA configuration block.
// Assumes a byte-wide register port with 16-bit addresses on one clock.
// Function
// [R1] Each channel has a 3-bit request selector (ch1 bits 6-4, ch0 bits 2-0) and code 000 picks the external request pin.
// [R2] Other selector codes pick serial receive-full, transmit-empty, sync serial holding-full or timer 2 output, the rest are reserved.
// [R3] Setting config bit 7 suppresses channel 1's active-low acknowledge at its pin.
// [R4] Setting config bit 3 suppresses channel 0's active-low acknowledge at its pin.
// [R5] One byte pointer picks the byte of a shared channel location and flips after every read or write there.
// [R6] Any write to F00CH clears the byte pointer to 0 regardless of data, and software issues it before programming.
// [R7] Channel 0 keeps a 4-byte requester address at two shared locations, shared low bytes of target and count, and direct upper bytes.
// [R8] Channel 1 uses the same arrangement at its own locations.
// [R9] Software loads the byte count with bytes to move minus one.
// [R10] For words software loads twice the word count minus one.
// [R11] A count in 16-bit mode expires on the decrement from 0000H to FFFFH.
// [R12] The byte pointer leaves reset at 0.
package dma_cfg_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    localparam int OVF_W = 4;

    // Register locations
    localparam logic [15:0] CH0_TGT_LO_ADDR = 16'hF000;
    localparam logic [15:0] CH0_CNT_LO_ADDR = 16'hF001;
    localparam logic [15:0] CH1_TGT_LO_ADDR = 16'hF002;
    localparam logic [15:0] CH1_CNT_LO_ADDR = 16'hF003;
    localparam logic [15:0] CLR_PTR_ADDR = 16'hF00C;
    localparam logic [15:0] CH0_REQ_LO_ADDR = 16'hF010;
    localparam logic [15:0] CH0_REQ_HI_ADDR = 16'hF011;
    localparam logic [15:0] CH1_REQ_LO_ADDR = 16'hF012;
    localparam logic [15:0] CH1_REQ_HI_ADDR = 16'hF013;
    localparam logic [15:0] OVF_ENABLE_ADDR = 16'hF01D;
    localparam logic [15:0] CH1_TGT_B2_ADDR = 16'hF083;
    localparam logic [15:0] CH1_TGT_B3_ADDR = 16'hF085;
    localparam logic [15:0] CH0_TGT_B3_ADDR = 16'hF086;
    localparam logic [15:0] CH0_TGT_B2_ADDR = 16'hF087;
    localparam logic [15:0] CH0_CNT_B2_ADDR = 16'hF098;
    localparam logic [15:0] CH1_CNT_B2_ADDR = 16'hF099;
    localparam logic [15:0] REQ_CFG_ADDR = 16'hF830;

    // Configuration fields
    localparam int CH1_MASK_BIT = 7;
    localparam int CH1_SEL_LSB = 4;
    localparam int CH0_MASK_BIT = 3;
    localparam int CH0_SEL_LSB = 0;
    localparam logic [7:0] REQ_CFG_RESET = 8'h00;

    // Overflow enable fields
    localparam int OVF_CH0_WIDE_BIT = 0;
    localparam int OVF_CH1_WIDE_BIT = 2;
    localparam logic [3:0] OVF_RESET = 4'hA;

    // Request source codes
    localparam logic [2:0] SRC_PIN = 3'h0;
    localparam logic [2:0] SRC_RX_FULL = 3'h1;
    localparam logic [2:0] SRC_TX_EMPTY = 3'h2;
    localparam logic [2:0] SRC_SYNC_RX = 3'h3;
    localparam logic [2:0] SRC_TIMER2 = 3'h4;

    localparam logic [31:0] CHAN_ADDR_RESET = 32'h0000_0000;
    localparam logic [23:0] CHAN_CNT_RESET = 24'h00_0000;

    typedef enum logic [1:0] {
        FLD_NONE,
        FLD_REQ,
        FLD_TGT,
        FLD_CNT
    } field_type;

    typedef struct packed {
        logic hit;
        logic shared;
        logic ch;
        field_type field;
        logic [1:0] byte_sel;
    } access_type;

    typedef struct packed {
        logic [31:0] requester_addr;
        logic [31:0] target_addr;
        logic [23:0] count;
    } channel_regs_type;

    typedef struct packed {
        logic [1:0] serial_rx_full;
        logic [1:0] serial_tx_empty;
        logic sync_serial_rx_holding_full;
        logic timer2_output;
    } int_src_type;

endpackage

// ===== rtl/dma_channel_config_regs.sv
// Request routing, acknowledge masking and byte-pointer channel registers.
// Assumes one 20 MHz clock, a synchronous active-low reset and pin requests.
`timescale 1ns/1ns
`default_nettype none

module dma_channel_config_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // External request pins
    input wire logic ch0_request_in,
    input wire logic ch1_request_in,
    // Internal requesters
    input wire dma_cfg_pkg::int_src_type int_src,
    // Transfer engine side
    input wire logic [1:0] ack_int,
    input wire logic [1:0] count_dec,
    output logic ch0_request,
    output logic ch1_request,
    output logic [1:0] count_expired,
    // Acknowledge pins
    output logic ch0_ack_n,
    output logic ch1_ack_n,
    // Register contents
    output dma_cfg_pkg::channel_regs_type ch0_regs,
    output dma_cfg_pkg::channel_regs_type ch1_regs,
    output logic [7:0] request_source_config,
    output logic [3:0] overflow_enable,
    output logic byte_pointer
);

    dma_cfg_pkg::channel_regs_type chan [2];
    dma_cfg_pkg::access_type wr_acc;
    dma_cfg_pkg::access_type rd_acc;
    logic [23:0] next_count [2];
    logic [1:0] count_wide;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [7:0] rd_byte;

    // Map an address and the pointer to a channel byte
    function automatic dma_cfg_pkg::access_type decode(
        input logic [15:0] a,
        input logic ptr
    );
        dma_cfg_pkg::access_type d;
        d.hit = 1'b1;
        d.shared = 1'b0;
        d.ch = 1'b0;
        d.field = dma_cfg_pkg::FLD_NONE;
        d.byte_sel = 2'h0;
        case (a)
            dma_cfg_pkg::CH0_REQ_LO_ADDR,
            dma_cfg_pkg::CH1_REQ_LO_ADDR: begin
                d.shared = 1'b1;
                d.field = dma_cfg_pkg::FLD_REQ;
                d.byte_sel = {1'b0, ptr};
            end
            dma_cfg_pkg::CH0_REQ_HI_ADDR,
            dma_cfg_pkg::CH1_REQ_HI_ADDR: begin
                d.shared = 1'b1;
                d.field = dma_cfg_pkg::FLD_REQ;
                d.byte_sel = {1'b1, ptr};
            end
            dma_cfg_pkg::CH0_TGT_LO_ADDR,
            dma_cfg_pkg::CH1_TGT_LO_ADDR: begin
                d.shared = 1'b1;
                d.field = dma_cfg_pkg::FLD_TGT;
                d.byte_sel = {1'b0, ptr};
            end
            dma_cfg_pkg::CH0_CNT_LO_ADDR,
            dma_cfg_pkg::CH1_CNT_LO_ADDR: begin
                d.shared = 1'b1;
                d.field = dma_cfg_pkg::FLD_CNT;
                d.byte_sel = {1'b0, ptr};
            end
            dma_cfg_pkg::CH0_TGT_B2_ADDR,
            dma_cfg_pkg::CH1_TGT_B2_ADDR: begin
                d.field = dma_cfg_pkg::FLD_TGT;
                d.byte_sel = 2'h2;
            end
            dma_cfg_pkg::CH0_TGT_B3_ADDR,
            dma_cfg_pkg::CH1_TGT_B3_ADDR: begin
                d.field = dma_cfg_pkg::FLD_TGT;
                d.byte_sel = 2'h3;
            end
            dma_cfg_pkg::CH0_CNT_B2_ADDR,
            dma_cfg_pkg::CH1_CNT_B2_ADDR: begin
                d.field = dma_cfg_pkg::FLD_CNT;
                d.byte_sel = 2'h2;
            end
            default: begin
                d.hit = 1'b0;
            end
        endcase
        // Channel 1 locations
        case (a)
            dma_cfg_pkg::CH1_REQ_LO_ADDR,
            dma_cfg_pkg::CH1_REQ_HI_ADDR,
            dma_cfg_pkg::CH1_TGT_LO_ADDR,
            dma_cfg_pkg::CH1_CNT_LO_ADDR,
            dma_cfg_pkg::CH1_TGT_B2_ADDR,
            dma_cfg_pkg::CH1_TGT_B3_ADDR,
            dma_cfg_pkg::CH1_CNT_B2_ADDR: d.ch = 1'b1;
            default: d.ch = 1'b0;
        endcase
        return d;
    endfunction

    // Pick one request source from a selector code
    function automatic logic route(
        input logic [2:0] sel,
        input logic pin,
        input logic rx_full,
        input logic tx_empty,
        input logic sync_rx,
        input logic timer2
    );
        logic r;
        r = 1'b0;
        case (sel)
            dma_cfg_pkg::SRC_PIN: r = pin; // [R1]
            dma_cfg_pkg::SRC_RX_FULL: r = rx_full; // [R2]
            dma_cfg_pkg::SRC_TX_EMPTY: r = tx_empty; // [R2]
            dma_cfg_pkg::SRC_SYNC_RX: r = sync_rx; // [R2]
            dma_cfg_pkg::SRC_TIMER2: r = timer2; // [R2]
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    assign wr_acc = decode(reg_addr, byte_pointer); // [R7] [R8]
    assign rd_acc = decode(reg_addr, byte_pointer);
    assign ch0_regs = chan[0];
    assign ch1_regs = chan[1];
    assign count_wide[0] = overflow_enable[dma_cfg_pkg::OVF_CH0_WIDE_BIT];
    assign count_wide[1] = overflow_enable[dma_cfg_pkg::OVF_CH1_WIDE_BIT];

    // Pin request synchroniser
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end else begin
            pin_meta <= {ch1_request_in, ch0_request_in};
            pin_sync <= pin_meta;
        end
    end

    // Configuration register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            request_source_config <= dma_cfg_pkg::REQ_CFG_RESET;
        end else if (reg_wr && reg_addr == dma_cfg_pkg::REQ_CFG_ADDR) begin
            request_source_config <= reg_wdata;
        end
    end

    // Overflow enable register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            overflow_enable <= dma_cfg_pkg::OVF_RESET;
        end else if (reg_wr && reg_addr == dma_cfg_pkg::OVF_ENABLE_ADDR) begin
            overflow_enable <= reg_wdata[3:0];
        end
    end

    // Byte pointer
    always_ff @(posedge clk) begin
        if (!nrst) begin
            byte_pointer <= 1'b0; // [R12]
        end else if (reg_wr && reg_addr == dma_cfg_pkg::CLR_PTR_ADDR) begin
            byte_pointer <= 1'b0; // [R6]
        end else if ((reg_wr && wr_acc.shared) ||
                     (reg_rd && rd_acc.shared)) begin
            byte_pointer <= ~byte_pointer; // [R5]
        end
    end

    // Decremented count values
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            if (count_wide[c]) begin
                next_count[c] = chan[c].count - 24'h00_0001;
            end else begin
                next_count[c] = {chan[c].count[23:16],
                                 chan[c].count[15:0] - 16'h0001};
            end
        end
    end

    // Channel registers, software write before decrement
    always_ff @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            if (!nrst) begin
                chan[c].requester_addr <= dma_cfg_pkg::CHAN_ADDR_RESET;
                chan[c].target_addr <= dma_cfg_pkg::CHAN_ADDR_RESET;
                chan[c].count <= dma_cfg_pkg::CHAN_CNT_RESET;
            end else if (reg_wr && wr_acc.hit && wr_acc.ch == 1'(c)) begin
                unique case (wr_acc.field)
                    dma_cfg_pkg::FLD_REQ:
                        chan[c].requester_addr[8*wr_acc.byte_sel +: 8]
                            <= reg_wdata; // [R7] [R8]
                    dma_cfg_pkg::FLD_TGT:
                        chan[c].target_addr[8*wr_acc.byte_sel +: 8]
                            <= reg_wdata; // [R7] [R8]
                    dma_cfg_pkg::FLD_CNT:
                        chan[c].count[8*wr_acc.byte_sel +: 8]
                            <= reg_wdata; // [R7] [R8]
                    dma_cfg_pkg::FLD_NONE: ;
                endcase
            end else if (count_dec[c]) begin
                chan[c].count <= next_count[c];
            end
        end
    end

    // Expiry on wrap to all ones
    always_ff @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            if (!nrst) begin
                count_expired[c] <= 1'b0;
            end else if (count_wide[c]) begin
                count_expired[c] <= count_dec[c] &&
                                    chan[c].count == 24'h00_0000;
            end else begin
                count_expired[c] <= count_dec[c] &&
                                    chan[c].count[15:0] == 16'h0000; // [R11]
            end
        end
    end

    // Request routing
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ch0_request <= 1'b0;
            ch1_request <= 1'b0;
        end else begin
            ch0_request <= route(
                request_source_config[dma_cfg_pkg::CH0_SEL_LSB +: 3],
                pin_sync[0],
                int_src.serial_rx_full[0],
                int_src.serial_tx_empty[1],
                int_src.sync_serial_rx_holding_full,
                int_src.timer2_output); // [R1] [R2]
            ch1_request <= route(
                request_source_config[dma_cfg_pkg::CH1_SEL_LSB +: 3],
                pin_sync[1],
                int_src.serial_rx_full[1],
                int_src.serial_tx_empty[0],
                int_src.sync_serial_rx_holding_full,
                int_src.timer2_output); // [R1] [R2]
        end
    end

    // Acknowledge pins with masking
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ch0_ack_n <= 1'b1;
            ch1_ack_n <= 1'b1;
        end else begin
            ch0_ack_n <= ~(ack_int[0] &
                ~request_source_config[dma_cfg_pkg::CH0_MASK_BIT]); // [R4]
            ch1_ack_n <= ~(ack_int[1] &
                ~request_source_config[dma_cfg_pkg::CH1_MASK_BIT]); // [R3]
        end
    end

    // Read data selection
    always_comb begin
        rd_byte = 8'h00;
        if (rd_acc.hit) begin
            unique case (rd_acc.field)
                dma_cfg_pkg::FLD_REQ:
                    rd_byte = chan[rd_acc.ch].requester_addr
                        [8*rd_acc.byte_sel +: 8];
                dma_cfg_pkg::FLD_TGT:
                    rd_byte = chan[rd_acc.ch].target_addr
                        [8*rd_acc.byte_sel +: 8];
                dma_cfg_pkg::FLD_CNT:
                    rd_byte = chan[rd_acc.ch].count[8*rd_acc.byte_sel +: 8];
                dma_cfg_pkg::FLD_NONE: rd_byte = 8'h00;
            endcase
        end else if (reg_addr == dma_cfg_pkg::REQ_CFG_ADDR) begin
            rd_byte = request_source_config;
        end else if (reg_addr == dma_cfg_pkg::OVF_ENABLE_ADDR) begin
            rd_byte = {4'h0, overflow_enable};
        end
    end

    // Read data register, valid only the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_byte;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // dma_channel_config_regs

`default_nettype wire

// ===== tb/dma_periph_model.sv
// Peripheral model that raises a DMA request pin on command.
// Assumes the acknowledge pin is active low and shares the bench clock.
`timescale 1ns/1ns
`default_nettype none

module dma_periph_model (
    // Clock
    input wire logic clk,
    // Bench control
    input wire logic want,
    // Pin side
    input wire logic ack_n,
    output logic request
);
    initial request = 1'b0;

    // Request held until acknowledged, then dropped
    always @(posedge clk) begin
        request <= want && ack_n;
    end
endmodule // dma_periph_model

`default_nettype wire

// ===== tb/dma_cfg_checker.sv
// Port assertions for the DMA configuration block.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module dma_cfg_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Watched ports
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic ch1_request_in,
    input wire dma_cfg_pkg::int_src_type int_src,
    input wire logic [1:0] ack_int,
    input wire logic [1:0] count_dec,
    input wire logic ch0_request,
    input wire logic ch1_request,
    input wire logic [1:0] count_expired,
    input wire logic ch0_ack_n,
    input wire logic ch1_ack_n,
    input wire dma_cfg_pkg::channel_regs_type ch0_regs,
    input wire logic [7:0] request_source_config,
    input wire logic [3:0] overflow_enable,
    input wire logic byte_pointer
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic shared;
    logic [7:0] cfg;
    logic zero0;
    assign shared = reg_addr[15:5] == 11'h780 && reg_addr[3:2] == 2'b00;
    assign cfg = request_source_config;
    assign zero0 = ch0_regs.count[15:0] == 16'h0000;

    property p_ack1;
        1'b1 |=> ch1_ack_n == !($past(ack_int[1]) && !$past(cfg[7]));
    endproperty
    a_ack1: assert property (p_ack1) else $error("ch1 ack mask");
    property p_ack0;
        1'b1 |=> ch0_ack_n == !($past(ack_int[0]) && !$past(cfg[3]));
    endproperty
    a_ack0: assert property (p_ack0) else $error("ch0 ack mask");
    property p_clear;
        reg_wr && reg_addr == 16'hF00C |=> !byte_pointer;
    endproperty
    a_clear: assert property (p_clear) else $error("pointer clear");
    property p_flip;
        (reg_wr || reg_rd) && shared |=> byte_pointer != $past(byte_pointer);
    endproperty
    a_flip: assert property (p_flip) else $error("pointer flip");
    property p_ptr_rst;
        disable iff (1'b0) !nrst |=> !byte_pointer;
    endproperty
    a_ptr_rst: assert property (p_ptr_rst) else $error("ptr reset");
    property p_pin;
        (cfg[6:4] == 3'h0 && ch1_request_in) [*3] |=> ch1_request;
    endproperty
    a_pin: assert property (p_pin) else $error("pin route");
    property p_timer;
        cfg[2:0] == 3'h4 |=> ch0_request == $past(int_src.timer2_output);
    endproperty
    a_timer: assert property (p_timer) else $error("timer route");
    property p_rsvd;
        cfg[6:4] > 3'h4 |=> !ch1_request;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved code");
    property p_exp;
        count_dec[0] && !overflow_enable[0] && zero0 && !reg_wr
            |=> count_expired[0];
    endproperty
    a_exp: assert property (p_exp) else $error("no expiry");
    property p_noexp;
        !(count_dec[0] && zero0) |=> !count_expired[0];
    endproperty
    a_noexp: assert property (p_noexp) else $error("false expiry");

    c_exp: cover property (count_expired[0]);
    c_clear: cover property (reg_wr && reg_addr == 16'hF00C);
    c_mask: cover property (ack_int[1] && cfg[7]);
endmodule // dma_cfg_checker

bind dma_channel_config_regs dma_cfg_checker dma_cfg_checker_i (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .ch1_request_in(ch1_request_in), .int_src(int_src),
    .ack_int(ack_int), .count_dec(count_dec), .ch0_request(ch0_request),
    .ch1_request(ch1_request), .count_expired(count_expired),
    .ch0_ack_n(ch0_ack_n), .ch1_ack_n(ch1_ack_n), .ch0_regs(ch0_regs),
    .request_source_config(request_source_config),
    .overflow_enable(overflow_enable), .byte_pointer(byte_pointer)
);

`default_nettype wire

// ===== tb/tb_dma_channel_config_regs.sv
// Self-checking bench for the DMA configuration block.
// Assumes the bound checker and one peripheral model per request pin.
`timescale 1ns/1ns
`default_nettype none

module tb_dma_channel_config_regs;
    logic clk, nrst, reg_wr, reg_rd, ch0_request_in, ch1_request_in;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, request_source_config;
    logic [1:0] ack_int, count_dec, count_expired, want;
    logic ch0_request, ch1_request, ch0_ack_n, ch1_ack_n, byte_pointer;
    logic [3:0] overflow_enable;
    dma_cfg_pkg::int_src_type int_src;
    dma_cfg_pkg::channel_regs_type ch0_regs, ch1_regs;
    int error_cnt = 0;
    int n_compared = 0;

    dma_channel_config_regs dma_channel_config_regs_i (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ch0_request_in(ch0_request_in), .ch1_request_in(ch1_request_in),
        .int_src(int_src), .ack_int(ack_int), .count_dec(count_dec),
        .ch0_request(ch0_request), .ch1_request(ch1_request),
        .count_expired(count_expired), .ch0_ack_n(ch0_ack_n),
        .ch1_ack_n(ch1_ack_n), .ch0_regs(ch0_regs), .ch1_regs(ch1_regs),
        .request_source_config(request_source_config),
        .overflow_enable(overflow_enable), .byte_pointer(byte_pointer)
    );
    dma_periph_model periph0_i (.clk(clk), .want(want[0]),
        .ack_n(ch0_ack_n), .request(ch0_request_in));
    dma_periph_model periph1_i (.clk(clk), .want(want[1]),
        .ack_n(ch1_ack_n), .request(ch1_request_in));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
        tick(1);
        chk(reg_rdata, 8'h00);
    endtask

    task automatic dec(input logic [1:0] m, input logic [1:0] e);
        @(posedge clk);
        count_dec <= m;
        @(posedge clk);
        count_dec <= 2'b00;
        #1;
        chk(count_expired, e);
    endtask

    task automatic t_pointer;
        logic [15:0] sh[8] = '{16'hF000, 16'hF001, 16'hF002, 16'hF003,
            16'hF010, 16'hF011, 16'hF012, 16'hF013};
        wr(16'hF000, 8'h55);
        wr(16'hF00C, 8'h5A);
        tick(0);
        chk(byte_pointer, 1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(sh[i], 8'(8'h10 + 2 * i));
            wr(sh[i], 8'(8'h11 + 2 * i));
        end
        wr(16'hF087, 8'hA0);
        wr(16'hF086, 8'hA1);
        wr(16'hF098, 8'hA2);
        wr(16'hF083, 8'hB0);
        wr(16'hF085, 8'hB1);
        wr(16'hF099, 8'hB2);
        tick(1);
        chk(ch0_regs.target_addr, 32'hA1A0_1110);
        chk(ch0_regs.count, 24'hA2_1312);
        chk(ch0_regs.requester_addr, 32'h1B1A_1918);
        chk(ch1_regs.target_addr, 32'hB1B0_1514);
        chk(ch1_regs.count, 24'hB2_1716);
        chk(ch1_regs.requester_addr, 32'h1F1E_1D1C);
        rd(16'hF010, 8'h18);
        rd(16'hF010, 8'h19);
        rd(16'hF013, 8'h1E);
        rd(16'hF00C, 8'h00);
        rd(16'hF004, 8'h00);
        rd(16'hF087, 8'hA0);
        rd(16'hF099, 8'hB2);
    endtask

    task automatic t_route;
        int idx[2][5] = '{'{0, 6, 5, 3, 2}, '{1, 7, 4, 3, 2}};
        logic [7:0] v;
        logic [2:0] c;
        logic s;
        for (int ch = 0; ch < 2; ch++) begin
            for (int k = 0; k < 16; k++) begin
                c = k[3:1];
                s = k[0];
                wr(16'hF830, ch ? {1'b0, c, 4'h0} : {5'h00, c});
                v = {8{~s}};
                if (c < 3'h5) v[idx[ch][c]] = s;
                {int_src, want} <= v;
                tick(6);
                chk(ch ? ch1_request : ch0_request, c < 3'h5 & s);
            end
        end
    endtask

    task automatic t_ack;
        for (int m = 0; m < 4; m++) begin
            wr(16'hF830, {m[1], 3'h0, m[0], 3'h0});
            ack_int <= 2'b11;
            want <= 2'b11;
            tick(2);
            chk({ch1_ack_n, ch0_ack_n}, m[1:0]);
            tick(6);
            chk({ch1_request, ch0_request}, m[1:0]);
            @(posedge clk);
            ack_int <= 2'b00;
            tick(6);
        end
        rd(16'hF830, 8'h88);
    endtask

    task automatic t_count;
        wr(16'hF00C, 8'h00);
        wr(16'hF001, 8'h01);
        wr(16'hF001, 8'h00);
        wr(16'hF098, 8'h55);
        dec(2'b01, 2'b00);
        dec(2'b01, 2'b01);
        chk(ch0_regs.count, 24'h55_FFFF);
        tick(1);
        chk(count_expired, 2'b00);
        wr(16'hF01D, 8'h04);
        rd(16'hF01D, 8'h04);
        chk(overflow_enable, 4'h4);
        wr(16'hF003, 8'h00);
        wr(16'hF003, 8'h00);
        wr(16'hF099, 8'h01);
        dec(2'b10, 2'b00);
        chk(ch1_regs.count, 24'h00_FFFF);
        wr(16'hF003, 8'h00);
        wr(16'hF003, 8'h00);
        wr(16'hF099, 8'h00);
        dec(2'b10, 2'b10);
        chk(ch1_regs.count, 24'hFF_FFFF);
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #300000;
        error_cnt++;
        $display("ERROR %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {int_src, want, ack_int, count_dec} = '0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        tick(1);
        chk(request_source_config, 8'h00);
        chk(overflow_enable, 4'hA);
        chk(byte_pointer, 1'b0);
        chk({ch1_ack_n, ch0_ack_n}, 2'b11);
        t_pointer();
        t_route();
        t_ack();
        t_count();
        test_done();
    end
endmodule // tb_dma_channel_config_regs

`default_nettype wire
